// *** design/wkt_params.svh ***
// wake timer constants: register offsets, field positions, reset values, clock rates
`ifndef WKT_PARAMS_SVH
`define WKT_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define WKT_OFF_STATUS    8'h04
`define WKT_OFF_INT_EN    8'h06
`define WKT_OFF_CTRL      8'h07
`define WKT_OFF_EXP       8'h14
`define WKT_OFF_MANT_HI   8'h15
`define WKT_OFF_MANT_LO   8'h16
`define WKT_OFF_CNT_HI    8'h17
`define WKT_OFF_CNT_LO    8'h18
`define WKT_OFF_DUTY      8'h19
`define WKT_OFF_CLEAR     8'h1a

// ****************************************************************
// field positions
// ****************************************************************
`define WKT_CTRL_ENWT     0
`define WKT_CTRL_XSEL     1
`define WKT_CTRL_LDC      2
`define WKT_EV_WAKE       0
`define WKT_EV_PACKET     1
`define WKT_EV_W          2

// ****************************************************************
// reset values
// ****************************************************************
`define WKT_RST_EXP       5'h03
`define WKT_RST_MANT      16'h0000
`define WKT_RST_DUTY      8'h00
`define WKT_RST_CTRL      3'h0
`define WKT_RST_EV        2'h0

// ****************************************************************
// timing
// ****************************************************************
`define WKT_CLK_HZ        25000000
`define WKT_LF_HZ         32768
`define WKT_UNIT_TICKS    32

`endif

// *** design/wkt_pkg.sv ***
// wake timer types
package wkt_pkg;

  typedef logic [7:0] wkt_addr_t;
  typedef logic [7:0] wkt_byte_t;

  typedef enum logic [2:0] {
    WKT_LDC_IDLE   = 3'b001,
    WKT_LDC_LISTEN = 3'b010,
    WKT_LDC_EXTEND = 3'b100
  } wkt_ldc_state_t;

endpackage

// *** design/wkt_sync.sv ***
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module wkt_sync (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  // level
  input  wire logic i_async,
  output logic      o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (i_clk_en) begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_q <= 1'b0;
    end else if (i_clk_en && (s2_q == s3_q)) begin
      out_q <= s3_q;
    end
  end

  assign o_level = out_q;

endmodule
`default_nettype wire

// *** design/wkt_lf_tick.sv ***
// low-frequency source select and rising-edge tick
`timescale 1ns/1ps
`default_nettype none

module wkt_lf_tick (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  // sources
  input  wire logic i_rc_osc,
  input  wire logic i_xtal_pin,
  input  wire logic i_sel_xtal,
  // tick
  output logic      o_tick
);

  logic [1:0] src_raw;
  logic [1:0] src_lvl;
  logic       sel_lvl;
  logic       prev_q;

  assign src_raw = {i_xtal_pin, i_rc_osc};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_src
      wkt_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_async   (src_raw[g]),
        .o_level   (src_lvl[g])
      );
    end
  endgenerate

  // a source switch may cost or add one tick; acceptable for a 32 khz timebase
  assign sel_lvl = i_sel_xtal ? src_lvl[1] : src_lvl[0];

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_q <= 1'b0;
    end else if (i_clk_en) begin
      prev_q <= sel_lvl;
    end
  end

  assign o_tick = i_clk_en & sel_lvl & ~prev_q;

endmodule
`default_nettype wire

// *** design/wkt_top.sv ***
// wake-up timer with low-duty-cycle receive control and register port
`timescale 1ns/1ps
`default_nettype none
`include "wkt_params.svh"

// Function
// - default timebase is 32.768 khz rc oscillator
// - enable bit at sleep entry arms counting
// - expiry raises interrupt only when enabled
// - live 16-bit count readable, high byte first
// - period is 32 times m times 2^r ticks
// - enabled expiry drives active-low interrupt low
// - interrupting expiry also enables the crystal
// - gpio-signalled expiry leaves state unchanged
// - crystal select turns gpio0 into crystal pin
// - crystal select clocks timer from external crystal
// - duty mode wakes receiver, sleeps without signal
// - preamble and sync extend on-time by duration
// - shared exponent scales duty on-time too
module wkt_top
  import wkt_pkg::*;
#(
  parameter int EXP_W  = 5,
  parameter int MANT_W = 16,
  parameter int DUTY_W = 8
) (
  // clock and reset
  input  wire logic           i_ref_clk,
  input  wire logic           i_sys_rst,
  input  wire logic           i_clk_en,
  // register port
  input  wire wkt_pkg::wkt_addr_t i_addr,
  input  wire wkt_pkg::wkt_byte_t i_wdata,
  input  wire logic           i_wr,
  input  wire logic           i_rd,
  output wkt_pkg::wkt_byte_t  o_rdata,
  // radio state
  input  wire logic           i_sleep,
  output logic                o_xtal_enable,
  output logic                o_lf_src_xtal,
  // low-frequency sources
  input  wire logic           i_rc_osc,
  input  wire logic           i_gpio0_in,
  // gpio0 pad
  input  wire logic           i_gpio0_dout,
  input  wire logic           i_gpio0_doe,
  output logic                o_gpio0_out,
  output logic                o_gpio0_oe,
  output logic                o_gpio0_xtal_mode,
  // wake signalling
  output logic                o_wake_gpio,
  output logic                o_interrupt_request_n,
  // receiver
  input  wire logic           i_preamble_valid,
  input  wire logic           i_sync_valid,
  input  wire logic           i_search_done,
  output logic                o_rx_enable
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // field widths fixed
  generate
    if (EXP_W != 5 || MANT_W != 16 || DUTY_W != 8) begin : g_bad_width
      $error("wkt_top: widths must be 5, 16 and 8");
    end
  endgenerate

  localparam int PRE_W = `WKT_UNIT_TICKS > 0 ? 5 + (1 << EXP_W) : 1;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [EXP_W-1:0]  exp_q;
  logic [MANT_W-1:0] mant_q;
  logic [DUTY_W-1:0] duty_q;
  logic [2:0]        ctrl_q;
  logic [1:0]        int_en_q;
  logic [1:0]        status_q;
  logic [1:0]        status_d;
  logic [1:0]        events;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;

  logic              lf_tick;
  logic              sleep_q;
  logic              armed_q;
  logic [PRE_W-1:0]  pre_q;
  logic [PRE_W-1:0]  unit_last;
  logic              unit_end;
  logic [MANT_W-1:0] count_q;
  logic              expire;

  wkt_ldc_state_t    ldc_state_q;
  logic [PRE_W-1:0]  ext_pre_q;
  logic [DUTY_W-1:0] ext_cnt_q;
  logic              ext_unit_end;
  logic              ext_done;
  logic              pkt_found;

  logic              xtal_q;
  logic              wake_gpio_q;
  logic              irq_n_q;
  logic              gpio0_out_q;
  logic              gpio0_oe_q;
  logic              rx_en_q;

  logic              wr_clear;

  // ****************************************************************
  // timebase
  // ****************************************************************
  // rc default, crystal when selected
  wkt_lf_tick u_tick (
    .i_ref_clk  (i_ref_clk),
    .i_sys_rst  (i_sys_rst),
    .i_clk_en   (i_clk_en),
    .i_rc_osc   (i_rc_osc),
    .i_xtal_pin (i_gpio0_in),
    .i_sel_xtal (ctrl_q[`WKT_CTRL_XSEL]),
    .o_tick     (lf_tick)
  );

  // last prescale index of one count unit: 32 * 2^exponent ticks
  function automatic logic [PRE_W-1:0] unit_len(input logic [EXP_W-1:0] e);
    logic [PRE_W:0] span;
    span = (PRE_W+1)'(`WKT_UNIT_TICKS) << e;
    return PRE_W'(span - (PRE_W+1)'(1));
  endfunction

  // one unit spans 32 * 2^r ticks
  assign unit_last = unit_len(exp_q);

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      exp_q    <= `WKT_RST_EXP;
      mant_q   <= `WKT_RST_MANT;
      duty_q   <= `WKT_RST_DUTY;
      ctrl_q   <= `WKT_RST_CTRL;
      int_en_q <= `WKT_RST_EV;
    end else if (i_clk_en && i_wr) begin
      if (i_addr == `WKT_OFF_EXP) begin
        exp_q <= i_wdata[EXP_W-1:0];
      end else if (i_addr == `WKT_OFF_MANT_HI) begin
        mant_q[15:8] <= i_wdata;
      end else if (i_addr == `WKT_OFF_MANT_LO) begin
        mant_q[7:0] <= i_wdata;
      end else if (i_addr == `WKT_OFF_DUTY) begin
        duty_q <= i_wdata;
      end else if (i_addr == `WKT_OFF_CTRL) begin
        ctrl_q <= i_wdata[2:0];
      end else if (i_addr == `WKT_OFF_INT_EN) begin
        int_en_q <= i_wdata[1:0];
      end
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_comb begin
    rdata_d = 8'h00;
    if (i_addr == `WKT_OFF_EXP) begin
      rdata_d = {3'h0, exp_q};
    end else if (i_addr == `WKT_OFF_MANT_HI) begin
      rdata_d = mant_q[15:8];
    end else if (i_addr == `WKT_OFF_MANT_LO) begin
      rdata_d = mant_q[7:0];
    end else if (i_addr == `WKT_OFF_CNT_HI) begin
      rdata_d = count_q[15:8];
    end else if (i_addr == `WKT_OFF_CNT_LO) begin
      rdata_d = count_q[7:0];
    end else if (i_addr == `WKT_OFF_DUTY) begin
      rdata_d = duty_q;
    end else if (i_addr == `WKT_OFF_CTRL) begin
      rdata_d = {5'h00, ctrl_q};
    end else if (i_addr == `WKT_OFF_INT_EN) begin
      rdata_d = {6'h00, int_en_q};
    end else if (i_addr == `WKT_OFF_STATUS) begin
      rdata_d = {6'h00, status_q};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= 8'h00;
    end else if (i_clk_en) begin
      rdata_q <= i_rd ? rdata_d : 8'h00;
    end
  end

  // ****************************************************************
  // arming
  // ****************************************************************
  // enable sampled on sleep entry
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (i_clk_en) begin
      sleep_q <= i_sleep;
      if (!ctrl_q[`WKT_CTRL_ENWT]) begin
        armed_q <= 1'b0;
      end else if (i_sleep && !sleep_q) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // period counter
  // ****************************************************************
  assign unit_end = armed_q && lf_tick && (pre_q >= unit_last);
  // a zero mantissa never expires
  assign expire   = unit_end && (mant_q != 16'h0000) && (count_q == mant_q - 16'h0001);

  // prescale 32 * 2^r ticks per count
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q <= '0;
    end else if (i_clk_en) begin
      if (!armed_q) begin
        pre_q <= '0;
      end else if (unit_end) begin
        pre_q <= '0;
      end else if (lf_tick) begin
        pre_q <= pre_q + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (!armed_q || expire) begin
        count_q <= 16'h0000;
      end else if (unit_end) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // low duty cycle receive
  // ****************************************************************
  assign pkt_found    = i_preamble_valid && i_sync_valid;
  assign ext_unit_end = lf_tick && (ext_pre_q >= unit_last);
  // on-time is duration units; zero ends at once
  assign ext_done     = (duty_q == 8'h00) ||
                        (ext_unit_end && (ext_cnt_q == duty_q - 8'h01));

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ldc_state_q <= WKT_LDC_IDLE;
    end else if (i_clk_en) begin
      case (ldc_state_q)
        WKT_LDC_IDLE: begin
          if (expire && ctrl_q[`WKT_CTRL_LDC]) begin
            ldc_state_q <= WKT_LDC_LISTEN;
          end
        end
        WKT_LDC_LISTEN: begin
          if (!ctrl_q[`WKT_CTRL_LDC]) begin
            ldc_state_q <= WKT_LDC_IDLE;
          end else if (pkt_found) begin
            ldc_state_q <= WKT_LDC_EXTEND;
          end else if (i_search_done) begin
            ldc_state_q <= WKT_LDC_IDLE;
          end
        end
        WKT_LDC_EXTEND: begin
          if (!ctrl_q[`WKT_CTRL_LDC] || ext_done) begin
            ldc_state_q <= WKT_LDC_IDLE;
          end
        end
        default: begin
          ldc_state_q <= WKT_LDC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_pre_q <= '0;
      ext_cnt_q <= 8'h00;
    end else if (i_clk_en) begin
      if (ldc_state_q != WKT_LDC_EXTEND) begin
        ext_pre_q <= '0;
        ext_cnt_q <= 8'h00;
      end else if (ext_unit_end) begin
        ext_pre_q <= '0;
        ext_cnt_q <= ext_cnt_q + 8'h01;
      end else if (lf_tick) begin
        ext_pre_q <= ext_pre_q + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_en_q <= 1'b0;
    end else if (i_clk_en) begin
      rx_en_q <= (ldc_state_q == WKT_LDC_LISTEN) || (ldc_state_q == WKT_LDC_EXTEND);
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  assign events[`WKT_EV_WAKE]   = expire;
  assign events[`WKT_EV_PACKET] = (ldc_state_q == WKT_LDC_LISTEN) && pkt_found;
  assign wr_clear = i_wr && (i_addr == `WKT_OFF_CLEAR);

  // an event in the clearing cycle survives the clear
  always_comb begin
    status_d = status_q;
    if (wr_clear) begin
      status_d = status_q & ~i_wdata[1:0];
    end
    status_d = status_d | events;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_q <= `WKT_RST_EV;
    end else if (i_clk_en) begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_n_q <= 1'b1;
    end else if (i_clk_en) begin
      irq_n_q <= ~|(status_d & int_en_q);
    end
  end

  // ****************************************************************
  // wake actions
  // ****************************************************************
  // crystal held on until host clears the wake cause
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      xtal_q <= 1'b0;
    end else if (i_clk_en) begin
      if (expire && int_en_q[`WKT_EV_WAKE]) begin
        xtal_q <= 1'b1;
      end else if (!status_q[`WKT_EV_WAKE]) begin
        xtal_q <= 1'b0;
      end
    end
  end

  // gpio pulse only, no state change
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_gpio_q <= 1'b0;
    end else if (i_clk_en) begin
      wake_gpio_q <= expire && !int_en_q[`WKT_EV_WAKE];
    end
  end

  // ****************************************************************
  // gpio0 pad
  // ****************************************************************
  // crystal mode releases the pad driver
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gpio0_out_q <= 1'b0;
      gpio0_oe_q  <= 1'b0;
    end else if (i_clk_en) begin
      gpio0_out_q <= ctrl_q[`WKT_CTRL_XSEL] ? 1'b0 : i_gpio0_dout;
      gpio0_oe_q  <= ctrl_q[`WKT_CTRL_XSEL] ? 1'b0 : i_gpio0_doe;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_rdata               = rdata_q;
  assign o_xtal_enable         = xtal_q;
  // host clock and duty logic follow the select
  assign o_lf_src_xtal         = ctrl_q[`WKT_CTRL_XSEL];
  assign o_gpio0_xtal_mode     = ctrl_q[`WKT_CTRL_XSEL];
  assign o_gpio0_out           = gpio0_out_q;
  assign o_gpio0_oe            = gpio0_oe_q;
  assign o_wake_gpio           = wake_gpio_q;
  assign o_interrupt_request_n = irq_n_q;
  assign o_rx_enable           = rx_en_q;

endmodule
`default_nettype wire

// *** sim/wkt_chk.sv ***
// concurrent checks on the wake timer top ports
`timescale 1ns/1ps
`default_nettype none
module wkt_chk
  import wkt_pkg::*;
(
  // clock and reset
  input wire logic               i_ref_clk,
  input wire logic               i_sys_rst,
  input wire logic               i_clk_en,
  // register port
  input wire wkt_pkg::wkt_addr_t i_addr,
  input wire wkt_pkg::wkt_byte_t i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire wkt_pkg::wkt_byte_t o_rdata,
  // pad and wake
  input wire logic               i_gpio0_dout,
  input wire logic               i_gpio0_doe,
  input wire logic               o_gpio0_out,
  input wire logic               o_gpio0_oe,
  input wire logic               o_gpio0_xtal_mode,
  input wire logic               o_wake_gpio,
  input wire logic               o_interrupt_request_n,
  input wire logic               o_xtal_enable,
  // receiver
  input wire logic               i_preamble_valid,
  input wire logic               i_sync_valid,
  input wire logic               i_search_done,
  input wire logic               o_rx_enable
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ****************************************
  // assertions
  // ****************************************
  // a frozen clock enable holds every register, so such cycles are left out
  a_rdata_idle: assert property ($past(i_clk_en) && !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data seen outside read slot");
  a_xtal_pad: assert property ($past(i_clk_en) && o_gpio0_xtal_mode
    && $past(o_gpio0_xtal_mode) |-> !o_gpio0_oe && !o_gpio0_out)
    else $error("pad driven while crystal selected");
  a_pad_copy: assert property ($past(i_clk_en) && !o_gpio0_xtal_mode
    && !$past(o_gpio0_xtal_mode)
    |-> o_gpio0_out == $past(i_gpio0_dout) && o_gpio0_oe == $past(i_gpio0_doe))
    else $error("pad does not follow its drive");
  a_wake_pulse: assert property (o_wake_gpio && i_clk_en |=> !o_wake_gpio)
    else $error("wake pulse longer than one cycle");
  a_irq_xtal: assert property ($rose(o_xtal_enable) |-> !o_interrupt_request_n)
    else $error("crystal request without interrupt");
  a_clear_drop: assert property (i_wr && i_addr == 8'h1a && i_wdata[0]
    |-> ##2 !o_xtal_enable)
    else $error("crystal request kept after clear");
  // an interrupt-enable write takes two cycles to reach the pin, so both are excluded
  a_irq_hold: assert property (!o_interrupt_request_n && !i_wr && !$past(i_wr)
    |=> !o_interrupt_request_n)
    else $error("interrupt released without clear");
  a_listen_end: assert property (i_search_done && o_rx_enable
    && !(i_preamble_valid && i_sync_valid) |-> ##[1:2] !o_rx_enable)
    else $error("receiver kept on after empty search");
  c_irq: cover property ($fell(o_interrupt_request_n));
  c_wake: cover property (o_wake_gpio);
  c_rx: cover property ($rose(o_rx_enable));
endmodule
`default_nettype wire

// *** sim/wkt_host.sv ***
// host model: register bus master and interrupt service
`timescale 1ns/1ps
`default_nettype none
module wkt_host
  import wkt_pkg::*;
(
  // clock
  input  wire logic               i_ref_clk,
  // register port toward the block
  output wkt_pkg::wkt_addr_t      o_addr,
  output wkt_pkg::wkt_byte_t      o_wdata,
  output logic                    o_wr,
  output logic                    o_rd,
  input  wire wkt_pkg::wkt_byte_t i_rdata
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input wkt_addr_t a, input wkt_byte_t d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe; taken at the edge that closes it
  task automatic rd(input wkt_addr_t a, output wkt_byte_t d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    @(posedge i_ref_clk);
    d = i_rdata;
  endtask
  task automatic service(output wkt_byte_t st);
    rd(8'h04, st);
    wr(8'h1a, st);
  endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the wake timer block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wkt_pkg::*;
  logic      clk, rst, ce, rc, xt, sleep, dout, doe, pre, syn, done, bus_wr, bus_rd;
  logic      xen, lfx, gout, goe, gxm, wgpio, irq_n, rxen;
  wkt_addr_t addr;
  wkt_byte_t wdata, rdata, b;
  int        errors, cmp_count, cyc, n;

  wkt_top dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata), .i_sleep(sleep), .o_xtal_enable(xen),
    .o_lf_src_xtal(lfx), .i_rc_osc(rc), .i_gpio0_in(xt), .i_gpio0_dout(dout),
    .i_gpio0_doe(doe), .o_gpio0_out(gout), .o_gpio0_oe(goe), .o_gpio0_xtal_mode(gxm),
    .o_wake_gpio(wgpio), .o_interrupt_request_n(irq_n), .i_preamble_valid(pre),
    .i_sync_valid(syn), .i_search_done(done), .o_rx_enable(rxen));
  wkt_host host (.i_ref_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(bus_wr),
    .o_rd(bus_rd), .i_rdata(rdata));

  // rc source 16 cycles, crystal 24 cycles, so a source mix-up moves every expiry
  initial begin clk = 1'b0; forever #20 clk = ~clk; end
  initial begin rc = 1'b0; forever #320 rc = ~rc; end
  initial begin xt = 1'b0; forever #480 xt = ~xt; end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    dout <= !rst & cyc[0];
    doe <= !rst & cyc[1];
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_on(input int s, output int k);
    k = 0;
    while (!(s == 0 ? irq_n === 1'b0 : s == 1 ? wgpio === 1'b1 : rxen === 1'b1) && k < 4000) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic cfg(input wkt_byte_t e, mh, ml, en, ct);
    host.wr(8'h14, e);
    host.wr(8'h15, mh);
    host.wr(8'h16, ml);
    host.wr(8'h06, en);
    host.wr(8'h07, ct);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [15:0] t [9] = '{16'h1403, 16'h1500, 16'h1600, 16'h1900, 16'h0600,
                           16'h0700, 16'h0400, 16'h3000, 16'h1a00};
    foreach (t[i]) begin
      host.rd(t[i][15:8], b);
      chk(b, t[i][7:0]);
    end
    host.wr(8'h14, 8'hff);
    host.wr(8'h19, 8'ha5);
    host.wr(8'h17, 8'hff);
    host.rd(8'h14, b);
    chk(b, 8'h1f);
    host.rd(8'h19, b);
    chk(b, 8'ha5);
    host.rd(8'h17, b);
    chk(b, 8'h00);
  endtask
  task automatic t_irq;
    cfg(8'h01, 8'h00, 8'h01, 8'h01, 8'h01);
    sleep <= 1'b1;
    wait_on(0, n);
    chk(n >= 990 && n <= 1060, 1'b1);
    chk(irq_n, 1'b0);
    chk(xen, 1'b1);
    host.service(b);
    chk(b, 8'h01);
    repeat (3) @(posedge clk);
    chk({irq_n, xen}, 2'b10);
    sleep <= 1'b0;
    host.wr(8'h07, 8'h00);
  endtask
  task automatic t_gpio;
    cfg(8'h00, 8'h00, 8'h02, 8'h00, 8'h01);
    sleep <= 1'b1;
    wait_on(1, n);
    chk(n >= 990 && n <= 1060, 1'b1);
    repeat (3) @(posedge clk);
    chk({irq_n, xen}, 2'b10);
    host.service(b);
    chk(b, 8'h01);
    sleep <= 1'b0;
    host.wr(8'h07, 8'h00);
  endtask
  task automatic t_count;
    cfg(8'h00, 8'h01, 8'h00, 8'h00, 8'h01);
    sleep <= 1'b1;
    repeat (1300) @(posedge clk);
    // frozen longer than one count unit, so a leaking enable shows as a third step
    ce <= 1'b0;
    repeat (600) @(posedge clk);
    ce <= 1'b1;
    host.rd(8'h17, b);
    chk(b, 8'h00);
    host.rd(8'h18, b);
    chk(b, 8'h02);
    host.wr(8'h07, 8'h00);
    sleep <= 1'b0;
  endtask
  task automatic t_xtal;
    cfg(8'h00, 8'h00, 8'h02, 8'h01, 8'h03);
    repeat (2) @(posedge clk);
    chk({gxm, lfx}, 2'b11);
    chk(goe, 1'b0);
    sleep <= 1'b1;
    wait_on(0, n);
    chk(n >= 1490 && n <= 1580, 1'b1);
    host.service(b);
    chk(b, 8'h01);
    sleep <= 1'b0;
    host.wr(8'h07, 8'h00);
  endtask
  task automatic t_duty;
    // exponent 1: on-time 64 ticks inside a 128-tick period
    host.wr(8'h19, 8'h01);
    cfg(8'h01, 8'h00, 8'h02, 8'h00, 8'h05);
    sleep <= 1'b1;
    wait_on(2, n);
    chk(n >= 2000 && n <= 2120, 1'b1);
    repeat (4) @(posedge clk);
    pre <= 1'b1;
    syn <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    syn <= 1'b0;
    n = 0;
    while (rxen === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 990 && n <= 1060, 1'b1);
    host.rd(8'h04, b);
    chk(b, 8'h03);
    host.wr(8'h1a, 8'h03);
    wait_on(2, n);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (3) @(posedge clk);
    chk(rxen, 1'b0);
    sleep <= 1'b0;
    host.wr(8'h07, 8'h00);
  endtask

  initial begin
    rst = 1'b1;
    sleep = 1'b0;
    pre = 1'b0;
    syn = 1'b0;
    done = 1'b0;
    ce = 1'b1;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_irq;
    t_gpio;
    t_count;
    t_xtal;
    t_duty;
    end_of_test;
  end
endmodule

bind wkt_top wkt_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio0_dout(i_gpio0_dout),
  .i_gpio0_doe(i_gpio0_doe), .o_gpio0_out(o_gpio0_out), .o_gpio0_oe(o_gpio0_oe),
  .o_gpio0_xtal_mode(o_gpio0_xtal_mode), .o_wake_gpio(o_wake_gpio),
  .o_interrupt_request_n(o_interrupt_request_n), .o_xtal_enable(o_xtal_enable),
  .i_preamble_valid(i_preamble_valid), .i_sync_valid(i_sync_valid),
  .i_search_done(i_search_done), .o_rx_enable(o_rx_enable));
`default_nettype wire
